// [rtl/dmr_params.svh]
// Constants for the mode register bank and burst address ordering
`ifndef DMR_PARAMS_SVH
`define DMR_PARAMS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define DMR_CLK_MHZ 40

// ----------------------------------------
// Mode register addresses
// ----------------------------------------
`define DMR_ADDR_INFO 8'h00
`define DMR_ADDR_FEATURE 8'h01
`define DMR_ADDR_IO_CAL 8'h0a

// ----------------------------------------
// Feature register fields and reset value
// ----------------------------------------
`define DMR_FEAT_RESET 8'h22
`define DMR_FEAT_BL_LSB 0
`define DMR_FEAT_BT_BIT 3
`define DMR_FEAT_WC_BIT 4
`define DMR_FEAT_NWR_LSB 5
`define DMR_BL4_CODE 3'h2
`define DMR_BL8_CODE 3'h3
`define DMR_BL16_CODE 3'h4
`define DMR_NWR_MIN_CODE 3'h1
`define DMR_NWR_MAX_CODE 3'h6
`define DMR_NWR_OFFSET 4'h2
`define DMR_NWR_DEFAULT 4'h3

// ----------------------------------------
// Information register fields
// ----------------------------------------
`define DMR_INFO_INIT_BIT 0
`define DMR_INFO_NVM_BIT 1
`define DMR_INFO_DNV_BIT 2
`define DMR_INFO_RZQ_LSB 3
`define DMR_RZQ_NONE 2'h0
`define DMR_RZQ_AT_SUPPLY 2'h1
`define DMR_RZQ_AT_GROUND 2'h2
`define DMR_RZQ_OK 2'h3

// ----------------------------------------
// Calibration command code
// ----------------------------------------
`define DMR_CAL_INIT_CODE 8'hff

// ----------------------------------------
// Timing
// ----------------------------------------
`define DMR_AUTO_INIT_TIME_NS 10000
`define DMR_AUTO_INIT_CYCLES ((`DMR_AUTO_INIT_TIME_NS * `DMR_CLK_MHZ + 999) / 1000)
`define DMR_CAL_TIME_NS 1000
`define DMR_CAL_CYCLES ((`DMR_CAL_TIME_NS * `DMR_CLK_MHZ + 999) / 1000)

`endif

// [rtl/dmr_pkg.sv]
// Types and shared decode for the mode register bank
package dmr_pkg;
`include "dmr_params.svh"

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_BURST = 3'b010,
      ST_RECOV = 3'b100
   } dmr_burst_state_e;

   typedef enum logic [1:0] {
      CAL_IDLE = 2'b01,
      CAL_RUN = 2'b10
   } dmr_cal_state_e;

   // Burst length code to beat count, reserved codes fall back to 4
   function automatic logic [4:0] dmr_bl_beats(input logic [2:0] code);
      logic [4:0] beats;
      case (code)
         `DMR_BL8_CODE: beats = 5'h08;
         `DMR_BL16_CODE: beats = 5'h10;
         default: beats = 5'h04;
      endcase
      return beats;
   endfunction : dmr_bl_beats

endpackage : dmr_pkg

// [rtl/dmr_cfg_if.sv]
// Burst settings and beat index passed to the address sequencer
`timescale 1ns/1ps
interface dmr_cfg_if;
   logic [2:0] bl_code;
   logic interleaved;
   logic no_wrap;
   logic [9:0] start_col;
   logic [3:0] beat;
   logic [9:0] col;

   modport ctrl (output bl_code, output interleaved, output no_wrap, output start_col, output beat, input col);
   modport seq (input bl_code, input interleaved, input no_wrap, input start_col, input beat, output col);
endinterface : dmr_cfg_if

// [rtl/dmr_burst_seq.sv]
// Column address of one burst beat
`timescale 1ns/1ps
module dmr_burst_seq
   import dmr_pkg::*;
(
   dmr_cfg_if.seq cfg
);

   logic [3:0] mask;
   logic [3:0] low;
   logic [4:0] beats;

   always_comb begin
      beats = dmr_bl_beats(cfg.bl_code);
      mask = 4'(beats - 5'h01);
      if (cfg.no_wrap) begin
         // Linear walk from y, no wrap
         low = 4'h0;
         cfg.col = cfg.start_col + {6'h00, cfg.beat};
      end else if (cfg.interleaved) begin
         low = (cfg.start_col[3:0] ^ cfg.beat) & mask;
         cfg.col = (cfg.start_col & ~{6'h00, mask}) | {6'h00, low};
      end else begin
         low = (cfg.start_col[3:0] + cfg.beat) & mask;
         cfg.col = (cfg.start_col & ~{6'h00, mask}) | {6'h00, low};
      end
   end

endmodule : dmr_burst_seq

// [rtl/dram_mode_reg_burst_order.sv]
// Mode register bank with burst address ordering and write recovery
`timescale 1ns/1ps
module dram_mode_reg_burst_order
   import dmr_pkg::*;
#(
   parameter logic IS_NONVOLATILE = 1'b0,
   parameter logic SELF_TEST_SUPPORTED = 1'b1
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic mr_cmd_valid_i,
   input wire logic mr_cmd_write_i,
   input wire logic [7:0] mr_addr_i,
   input wire logic [7:0] mr_wdata_i,
   output logic mr_rvalid_o,
   output logic [7:0] mr_rdata_o,
   input wire logic burst_start_i,
   input wire logic burst_write_i,
   input wire logic burst_auto_precharge_i,
   input wire logic [8:0] burst_col_i,
   output logic burst_valid_o,
   output logic burst_last_o,
   output logic [9:0] burst_col_o,
   output logic burst_busy_o,
   output logic precharge_start_o,
   input wire logic cal_pin_at_supply_i,
   input wire logic cal_pin_at_ground_i,
   input wire logic cal_pin_resistor_i,
   output logic cal_busy_o,
   output logic factory_trim_o
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [7:0] feature_reg;
   logic [7:0] feature_next;
   logic mr_rvalid_reg;
   logic mr_rvalid_next;
   logic [7:0] mr_rdata_reg;
   logic [7:0] mr_rdata_next;
   logic [8:0] init_cnt_reg;
   logic [8:0] init_cnt_next;
   logic init_busy_reg;
   logic init_busy_next;
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   dmr_cal_state_e cal_state_reg;
   dmr_cal_state_e cal_state_next;
   logic [5:0] cal_cnt_reg;
   logic [5:0] cal_cnt_next;
   logic cal_is_init_reg;
   logic cal_is_init_next;
   logic [1:0] rzq_result_reg;
   logic [1:0] rzq_result_next;
   dmr_burst_state_e state_reg;
   dmr_burst_state_e state_next;
   logic [2:0] bl_code_reg;
   logic [2:0] bl_code_next;
   logic interleaved_reg;
   logic interleaved_next;
   logic no_wrap_reg;
   logic no_wrap_next;
   logic [3:0] nwr_reg;
   logic [3:0] nwr_next;
   logic [9:0] start_col_reg;
   logic [9:0] start_col_next;
   logic write_ap_reg;
   logic write_ap_next;
   logic [3:0] beat_reg;
   logic [3:0] beat_next;
   logic [3:0] recov_cnt_reg;
   logic [3:0] recov_cnt_next;
   logic valid_reg;
   logic valid_next;
   logic last_reg;
   logic last_next;
   logic [9:0] col_reg;
   logic [9:0] col_next;
   logic pre_reg;
   logic pre_next;
   logic mr_write;
   logic mr_read;
   logic cal_blocked;
   logic last_beat;

   dmr_cfg_if cfg ();

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   // Write recovery code to cycles, reserved codes keep the default
   function automatic logic [3:0] nwr_cycles(input logic [2:0] code);
      logic [3:0] cycles;
      if (code >= `DMR_NWR_MIN_CODE && code <= `DMR_NWR_MAX_CODE) begin
         cycles = {1'b0, code} + `DMR_NWR_OFFSET;
      end else begin
         cycles = `DMR_NWR_DEFAULT;
      end
      return cycles;
   endfunction : nwr_cycles

   // Result codes that flag a possible assembly error
   function automatic logic rzq_fault(input logic [1:0] code);
      return (code == `DMR_RZQ_AT_SUPPLY) || (code == `DMR_RZQ_AT_GROUND);
   endfunction : rzq_fault

   assign mr_write = mr_cmd_valid_i && mr_cmd_write_i;
   assign mr_read = mr_cmd_valid_i && !mr_cmd_write_i;
   assign cal_blocked = rzq_fault(rzq_result_reg);

   // ----------------------------------------
   // Mode register access
   // ----------------------------------------
   always_comb begin
      feature_next = feature_reg;
      mr_rvalid_next = mr_read;
      mr_rdata_next = 8'h00;
      // Only the feature address stores, the information register ignores writes
      if (mr_write && mr_addr_i == `DMR_ADDR_FEATURE) begin
         feature_next = mr_wdata_i;
      end
      if (mr_read && mr_addr_i == `DMR_ADDR_INFO) begin
         mr_rdata_next[`DMR_INFO_INIT_BIT] = init_busy_reg;
         mr_rdata_next[`DMR_INFO_NVM_BIT] = IS_NONVOLATILE;
         mr_rdata_next[`DMR_INFO_DNV_BIT] = 1'b0;
         mr_rdata_next[`DMR_INFO_RZQ_LSB +: 2] = rzq_result_reg;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         feature_reg <= `DMR_FEAT_RESET;
         mr_rvalid_reg <= 1'b0;
         mr_rdata_reg <= 8'h00;
      end else if (ce_i) begin
         feature_reg <= feature_next;
         mr_rvalid_reg <= mr_rvalid_next;
         mr_rdata_reg <= mr_rdata_next;
      end
   end

   // ----------------------------------------
   // Auto-initialization status
   // ----------------------------------------
   always_comb begin
      init_cnt_next = init_cnt_reg;
      init_busy_next = init_busy_reg;
      if (init_busy_reg) begin
         if (init_cnt_reg == 9'(`DMR_AUTO_INIT_CYCLES - 1)) begin
            init_busy_next = 1'b0;
         end else begin
            init_cnt_next = init_cnt_reg + 9'h001;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         init_cnt_reg <= 9'h000;
         init_busy_reg <= 1'b1;
      end else if (ce_i) begin
         init_cnt_reg <= init_cnt_next;
         init_busy_reg <= init_busy_next;
      end
   end

   // ----------------------------------------
   // Calibration pin synchroniser
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_meta_reg <= 3'h0;
         pin_sync_reg <= 3'h0;
      end else if (ce_i) begin
         pin_meta_reg <= {cal_pin_resistor_i, cal_pin_at_ground_i, cal_pin_at_supply_i};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ----------------------------------------
   // Calibration and resistor self-test
   // ----------------------------------------
   always_comb begin
      cal_state_next = cal_state_reg;
      cal_cnt_next = cal_cnt_reg;
      cal_is_init_next = cal_is_init_reg;
      rzq_result_next = rzq_result_reg;
      case (cal_state_reg)
         CAL_IDLE: begin
            // Calibration commands are dropped after an assembly fault
            if (mr_write && mr_addr_i == `DMR_ADDR_IO_CAL && !cal_blocked) begin
               cal_state_next = CAL_RUN;
               cal_cnt_next = 6'h00;
               cal_is_init_next = (mr_wdata_i == `DMR_CAL_INIT_CODE);
            end
         end
         CAL_RUN: begin
            if (cal_cnt_reg == 6'(`DMR_CAL_CYCLES - 1)) begin
               cal_state_next = CAL_IDLE;
               if (cal_is_init_reg) begin
                  if (!SELF_TEST_SUPPORTED) begin
                     rzq_result_next = `DMR_RZQ_NONE;
                  end else if (pin_sync_reg[0]) begin
                     rzq_result_next = `DMR_RZQ_AT_SUPPLY;
                  end else if (pin_sync_reg[1]) begin
                     rzq_result_next = `DMR_RZQ_AT_GROUND;
                  end else if (pin_sync_reg[2]) begin
                     rzq_result_next = `DMR_RZQ_OK;
                  end else begin
                     rzq_result_next = `DMR_RZQ_AT_SUPPLY;
                  end
               end
            end else begin
               cal_cnt_next = cal_cnt_reg + 6'h01;
            end
         end
         default: begin
            cal_state_next = CAL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cal_state_reg <= CAL_IDLE;
         cal_cnt_reg <= 6'h00;
         cal_is_init_reg <= 1'b0;
         rzq_result_reg <= `DMR_RZQ_NONE;
      end else if (ce_i) begin
         cal_state_reg <= cal_state_next;
         cal_cnt_reg <= cal_cnt_next;
         cal_is_init_reg <= cal_is_init_next;
         rzq_result_reg <= rzq_result_next;
      end
   end

   // ----------------------------------------
   // Burst sequencer
   // ----------------------------------------
   assign cfg.bl_code = bl_code_reg;
   assign cfg.interleaved = interleaved_reg;
   assign cfg.no_wrap = no_wrap_reg;
   assign cfg.start_col = start_col_reg;
   assign cfg.beat = beat_reg;

   dmr_burst_seq u_seq (
      .cfg(cfg.seq)
   );

   assign last_beat = ({1'b0, beat_reg} == dmr_bl_beats(bl_code_reg) - 5'h01);

   always_comb begin
      state_next = state_reg;
      bl_code_next = bl_code_reg;
      interleaved_next = interleaved_reg;
      no_wrap_next = no_wrap_reg;
      nwr_next = nwr_reg;
      start_col_next = start_col_reg;
      write_ap_next = write_ap_reg;
      beat_next = beat_reg;
      recov_cnt_next = recov_cnt_reg;
      valid_next = 1'b0;
      last_next = 1'b0;
      col_next = col_reg;
      pre_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (burst_start_i) begin
               // Settings are sampled per burst from the current feature register
               bl_code_next = feature_reg[`DMR_FEAT_BL_LSB +: 3];
               interleaved_next = feature_reg[`DMR_FEAT_BT_BIT];
               no_wrap_next = feature_reg[`DMR_FEAT_WC_BIT];
               nwr_next = nwr_cycles(feature_reg[`DMR_FEAT_NWR_LSB +: 3]);
               start_col_next = {burst_col_i, 1'b0};
               write_ap_next = burst_write_i && burst_auto_precharge_i;
               beat_next = 4'h0;
               state_next = ST_BURST;
            end
         end
         ST_BURST: begin
            valid_next = 1'b1;
            last_next = last_beat;
            col_next = cfg.col;
            beat_next = beat_reg + 4'h1;
            if (last_beat) begin
               beat_next = 4'h0;
               if (write_ap_reg) begin
                  recov_cnt_next = nwr_reg;
                  state_next = ST_RECOV;
               end else begin
                  state_next = ST_IDLE;
               end
            end
         end
         ST_RECOV: begin
            recov_cnt_next = recov_cnt_reg - 4'h1;
            if (recov_cnt_reg == 4'h1) begin
               pre_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= ST_IDLE;
         bl_code_reg <= `DMR_BL4_CODE;
         interleaved_reg <= 1'b0;
         no_wrap_reg <= 1'b0;
         nwr_reg <= `DMR_NWR_DEFAULT;
         start_col_reg <= 10'h000;
         write_ap_reg <= 1'b0;
         beat_reg <= 4'h0;
         recov_cnt_reg <= 4'h0;
         valid_reg <= 1'b0;
         last_reg <= 1'b0;
         col_reg <= 10'h000;
         pre_reg <= 1'b0;
      end else if (ce_i) begin
         state_reg <= state_next;
         bl_code_reg <= bl_code_next;
         interleaved_reg <= interleaved_next;
         no_wrap_reg <= no_wrap_next;
         nwr_reg <= nwr_next;
         start_col_reg <= start_col_next;
         write_ap_reg <= write_ap_next;
         beat_reg <= beat_next;
         recov_cnt_reg <= recov_cnt_next;
         valid_reg <= valid_next;
         last_reg <= last_next;
         col_reg <= col_next;
         pre_reg <= pre_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign mr_rvalid_o = mr_rvalid_reg;
   assign mr_rdata_o = mr_rdata_reg;
   assign burst_valid_o = valid_reg;
   assign burst_last_o = last_reg;
   assign burst_col_o = col_reg;
   assign burst_busy_o = (state_reg != ST_IDLE);
   assign precharge_start_o = pre_reg;
   assign cal_busy_o = (cal_state_reg == CAL_RUN);
   assign factory_trim_o = cal_blocked;

endmodule : dram_mode_reg_burst_order

// [tb/dmr_monitor.sv]
// Checker of the mode register bank ports
`timescale 1ns/1ps
module dmr_monitor
   import dmr_pkg::*;
#(
   parameter logic IS_NONVOLATILE = 1'b0,
   parameter logic SELF_TEST_SUPPORTED = 1'b1
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic mr_cmd_valid_i,
   input wire logic mr_cmd_write_i,
   input wire logic [7:0] mr_addr_i,
   input wire logic [7:0] mr_wdata_i,
   input wire logic mr_rvalid_o,
   input wire logic [7:0] mr_rdata_o,
   input wire logic burst_start_i,
   input wire logic burst_write_i,
   input wire logic burst_auto_precharge_i,
   input wire logic [8:0] burst_col_i,
   input wire logic burst_valid_o,
   input wire logic burst_last_o,
   input wire logic [9:0] burst_col_o,
   input wire logic burst_busy_o,
   input wire logic precharge_start_o,
   input wire logic cal_pin_at_supply_i,
   input wire logic cal_pin_at_ground_i,
   input wire logic cal_pin_resistor_i,
   input wire logic cal_busy_o,
   input wire logic factory_trim_o
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic rd_take;
   logic cal_take;
   assign rd_take = ce_i && mr_cmd_valid_i && !mr_cmd_write_i;
   assign cal_take = ce_i && mr_cmd_valid_i && mr_cmd_write_i && mr_addr_i == 8'h0a;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_read_answer_next: assert property (rd_take |=> mr_rvalid_o)
      else $error("read answer missing");
   a_answer_has_cause: assert property (mr_rvalid_o |-> $past(rd_take))
      else $error("read answer without read");
   a_info_fixed_bits: assert property (mr_rvalid_o && $past(mr_addr_i) == 8'h00 |->
      mr_rdata_o[7:5] == 3'h0 && mr_rdata_o[2:1] == {1'b0, IS_NONVOLATILE})
      else $error("information fixed bits wrong");
   a_other_reads_zero: assert property (mr_rvalid_o && $past(mr_addr_i) != 8'h00 |-> mr_rdata_o == 8'h00)
      else $error("non information read not zero");
   a_trim_by_code: assert property (mr_rvalid_o && $past(mr_addr_i) == 8'h00 |->
      factory_trim_o == (mr_rdata_o[4:3] inside {2'h1, 2'h2}))
      else $error("factory trim disagrees with result");
   a_cal_ignored_trim: assert property (factory_trim_o && !cal_busy_o && cal_take |=> !cal_busy_o)
      else $error("calibration ran under factory trim");
   a_cal_runs_after: assert property (cal_take && !cal_busy_o && !factory_trim_o |=> cal_busy_o [*8])
      else $error("calibration did not run");
   a_first_beat_two: assert property (burst_start_i && ce_i && !burst_busy_o |=>
      burst_busy_o && !burst_valid_o ##1 burst_valid_o)
      else $error("first beat not two cycles after start");
   a_beats_end_last: assert property (burst_last_o |-> burst_valid_o ##1 !burst_valid_o)
      else $error("beats continue after last");
   a_beats_unbroken: assert property (burst_valid_o && !burst_last_o |=> burst_valid_o)
      else $error("gap inside burst");
   a_recovery_min_three: assert property (precharge_start_o |-> !$past(burst_last_o) && !$past(burst_last_o, 2))
      else $error("precharge too soon after last beat");

   // ----------------------------------------
   // Covers
   // ----------------------------------------
   c_info_read: cover property (mr_rvalid_o && $past(mr_addr_i) == 8'h00);
   c_precharge: cover property (precharge_start_o);
   c_cal_done: cover property ($fell(cal_busy_o));
endmodule : dmr_monitor

bind dram_mode_reg_burst_order dmr_monitor #(
   .IS_NONVOLATILE(IS_NONVOLATILE),
   .SELF_TEST_SUPPORTED(SELF_TEST_SUPPORTED)
) u_mon (.*);

// [tb/dmr_ctrl_model.sv]
// Memory controller model issuing mode register commands and bursts
`timescale 1ns/1ps
module dmr_ctrl_model (
   input wire logic clk_i,
   input wire logic [7:0] mr_rdata_o,
   output logic ce_i,
   output logic mr_cmd_valid_i,
   output logic mr_cmd_write_i,
   output logic [7:0] mr_addr_i,
   output logic [7:0] mr_wdata_i,
   output logic burst_start_i,
   output logic burst_write_i,
   output logic burst_auto_precharge_i,
   output logic [8:0] burst_col_i
);
   initial begin
      ce_i = 1'b1;
      mr_cmd_valid_i = 1'b0;
      mr_cmd_write_i = 1'b0;
      mr_addr_i = 8'h00;
      mr_wdata_i = 8'h00;
      burst_start_i = 1'b0;
      burst_write_i = 1'b0;
      burst_auto_precharge_i = 1'b0;
      burst_col_i = 9'h000;
   end

   // ----------------------------------------
   // Mode register commands
   // ----------------------------------------
   task automatic mr_cmd(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk_i);
      mr_cmd_valid_i = 1'b1;
      mr_cmd_write_i = wr;
      mr_addr_i = addr;
      mr_wdata_i = data;
      @(negedge clk_i);
      mr_cmd_valid_i = 1'b0;
      mr_addr_i = ~addr;
      mr_wdata_i = ~data;
   endtask : mr_cmd

   task automatic mr_read(input logic [7:0] addr, output logic [7:0] data);
      mr_cmd(1'b0, addr, 8'h00);
      data = mr_rdata_o;
   endtask : mr_read

   // Legal codes only, reserved bits zero, no wrap never with length 8
   task automatic set_feature(input logic [2:0] bl, input logic bt, input logic wc, input logic [2:0] write_recovery_cycles);
      if (!(wc && bl == 3'h3)) begin
         mr_cmd(1'b1, 8'h01, {write_recovery_cycles, wc, bt, bl});
      end
   endtask : set_feature

   // ----------------------------------------
   // Burst request, column bit 0 not carried
   // ----------------------------------------
   task automatic burst(input logic [8:0] col, input logic wr, input logic ap);
      @(negedge clk_i);
      burst_start_i = 1'b1;
      burst_write_i = wr;
      burst_auto_precharge_i = ap;
      burst_col_i = col;
      @(negedge clk_i);
      burst_start_i = 1'b0;
      burst_write_i = ~wr;
      burst_auto_precharge_i = ~ap;
      burst_col_i = ~col;
   endtask : burst

   // Clock enable level, changed by the caller at a falling edge
   task automatic set_ce(input logic en);
      ce_i = en;
   endtask : set_ce
endmodule : dmr_ctrl_model

// [tb/tb_top.sv]
// Testbench of the mode register bank and burst ordering
`timescale 1ns/1ps
module tb_top;
   import dmr_pkg::*;
   logic clk_i, resetn_i, ce_i, mr_cmd_valid_i, mr_cmd_write_i, mr_rvalid_o;
   logic [7:0] mr_addr_i, mr_wdata_i, mr_rdata_o;
   logic burst_start_i, burst_write_i, burst_auto_precharge_i;
   logic [8:0] burst_col_i;
   logic burst_valid_o, burst_last_o, burst_busy_o, precharge_start_o;
   logic [9:0] burst_col_o;
   logic cal_pin_at_supply_i, cal_pin_at_ground_i, cal_pin_resistor_i, cal_busy_o, factory_trim_o;
   logic [7:0] d;
   int num_errors, checks, i;

   dram_mode_reg_burst_order uut (.*);
   dmr_ctrl_model u_ctrl (.*);

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // ----------------------------------------
   // Reporting
   // ----------------------------------------
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic verify(input bit ok, input string msg);
      checks++;
      if (!ok) begin
         num_errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : verify

   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic reset_dut();
      resetn_i = 1'b0;
      repeat (10) @(negedge clk_i);
      resetn_i = 1'b1;
      repeat (410) @(negedge clk_i);
   endtask : reset_dut

   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      u_ctrl.mr_read(addr, data);
      verify(mr_rvalid_o === 1'b1, "no read answer");
   endtask : rd

   function automatic logic [9:0] exp_col(input int bl, input logic bt, input logic wc,
                                          input logic [9:0] s, input int k);
      logic [9:0] m;
      m = 10'(bl - 1);
      if (wc) return s + 10'(k);
      if (bt) return s ^ 10'(k);
      return (s & ~m) | ((s + 10'(k)) & m);
   endfunction : exp_col

   task automatic run_burst(input int bl, input logic bt, input logic wc, input logic [8:0] c, input int write_recovery_cycles);
      int k;
      int j;
      k = 0;
      u_ctrl.burst(c, write_recovery_cycles > 0, write_recovery_cycles > 0);
      for (j = 0; j < 40 && k < bl; j++) begin
         @(negedge clk_i);
         if (burst_valid_o === 1'b1) begin
            verify(burst_col_o === exp_col(bl, bt, wc, {c, 1'b0}, k), "beat column");
            verify(burst_last_o === 1'(k == bl - 1), "last flag");
            verify(burst_busy_o === 1'(k != bl - 1 || write_recovery_cycles > 0), "busy level");
            k++;
         end
      end
      verify(k == bl, "beat count");
      if (k != bl) complete_run();
      if (write_recovery_cycles > 0) begin
         for (j = 0; j < 20 && precharge_start_o !== 1'b1; j++) @(negedge clk_i);
         verify(j == write_recovery_cycles, "recovery cycles");
         verify(burst_busy_o === 1'b0, "busy after precharge");
         if (j == 20) complete_run();
      end
   endtask : run_burst

   task automatic cal_case(input logic [2:0] pins, input logic [1:0] code);
      int j;
      {cal_pin_at_supply_i, cal_pin_at_ground_i, cal_pin_resistor_i} = pins;
      repeat (4) @(negedge clk_i);
      u_ctrl.mr_cmd(1'b1, 8'h0a, 8'hff);
      for (j = 0; j < 60 && cal_busy_o !== 1'b0; j++) @(negedge clk_i);
      if (j == 60) begin
         verify(1'b0, "calibration hang");
         complete_run();
      end
      rd(8'h00, d);
      verify(d[4:3] === code, "self test result");
      verify(factory_trim_o === 1'(code inside {2'h1, 2'h2}), "factory trim");
   endtask : cal_case

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      num_errors = 0;
      checks = 0;
      resetn_i = 1'b0;
      {cal_pin_at_supply_i, cal_pin_at_ground_i, cal_pin_resistor_i} = 3'h0;
      repeat (10) @(negedge clk_i);
      resetn_i = 1'b1;
      rd(8'h00, d);
      verify({d[7:5], d[2:0]} === 6'h01, "auto init busy");
      repeat (410) @(negedge clk_i);
      rd(8'h00, d);
      verify({d[7:5], d[2:0]} === 6'h00, "auto init done");
      u_ctrl.mr_cmd(1'b1, 8'h00, 8'hff);
      // A read offered while the clock enable is low is not taken
      u_ctrl.set_ce(1'b0);
      u_ctrl.mr_cmd(1'b0, 8'h00, 8'h00);
      verify(mr_rvalid_o === 1'b0, "read under freeze");
      u_ctrl.set_ce(1'b1);
      rd(8'h00, d);
      verify({d[7:5], d[2:0]} === 6'h00, "read only write");
      rd(8'h01, d);
      verify(d === 8'h00, "feature read");
      cal_case(3'h1, 2'h3);
      cal_case(3'h2, 2'h2);
      cal_case(3'h4, 2'h2);
      run_burst(4, 1'b0, 1'b0, 9'h001, 0);
      u_ctrl.set_feature(3'h3, 1'b0, 1'b0, 3'h1);
      run_burst(8, 1'b0, 1'b0, 9'h003, 0);
      u_ctrl.set_feature(3'h3, 1'b1, 1'b0, 3'h1);
      for (i = 0; i < 4; i++) run_burst(8, 1'b1, 1'b0, {7'h05, 2'(i)}, 0);
      u_ctrl.set_feature(3'h2, 1'b0, 1'b1, 3'h1);
      run_burst(4, 1'b0, 1'b1, 9'h005, 0);
      u_ctrl.set_feature(3'h4, 1'b0, 1'b0, 3'h1);
      run_burst(16, 1'b0, 1'b0, 9'h001, 0);
      for (i = 1; i <= 6; i++) begin
         u_ctrl.set_feature(3'h2, 1'b0, 1'b0, 3'(i));
         run_burst(4, 1'b0, 1'b0, 9'h002, i + 2);
      end
      reset_dut();
      cal_case(3'h4, 2'h1);
      complete_run();
   end
endmodule : tb_top
